// ---- hdl/sir_router.v ----
// Interrupt enable, routing and pin logic of the motion-sensor device.
`timescale 1ns/100ps
`default_nettype none
`include "sir_defs.vh"


module sir_router
(
  input wire clk,
  input wire reset_n,
  // Register port of the device, driven by the serial bus decoder.
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWriteData,
  input wire regRead,
  output reg [7:0] regReadData,
  // Event flags of the functional blocks below auto-sleep, bits 6 to 0.
  input wire [6:0] sourceFlags,
  // Current system mode: high while the device is in sleep mode.
  input wire sleepMode,
  // Magnetic interrupts, already enabled and routed elsewhere.
  input wire magToFirst,
  input wire magToSecond,
  // Pin controls from the neighbouring interrupt control register.
  input wire polarityHigh,
  input wire pinDriveKind,
  // Sticky auto-sleep/wake event flag, for the source status register.
  output reg sleepEventFlag,
  // Enabled flags, for the source status logic.
  output reg [7:0] enabledFlags,
  // The two interrupt pins as output and output enable.
  output wire eventPinFirst,
  output wire eventPinFirstEnable,
  output wire eventPinSecond,
  output wire eventPinSecondEnable
);

  // Software-visible registers.
  reg [7:0] interruptEnable;
  reg [7:0] interruptRouting;

  // Previous sleep state and a mark that it has been sampled once.
  reg sleepModeLast;
  reg sleepPrimed;

  // All eight raw flags, auto-sleep flag on top.
  wire [7:0] rawFlags;

  // Enabled flags, combinational.
  wire [7:0] next_enabledFlags;

  // Per-source contribution to each pin.
  wire [7:0] toFirst;
  wire [7:0] toSecond;

  // Combined requests for each pin.
  wire firstActive;
  wire secondActive;

  // Decoded register accesses and the sleep-mode change.
  wire writeEnable;
  wire writeRouting;
  wire readSysMode;
  wire sleepChange;

  assign writeEnable = regWrite && (regAddr == `SIR_ADDR_ENABLE);
  assign writeRouting = regWrite && (regAddr == `SIR_ADDR_ROUTING);
  assign readSysMode = regRead && (regAddr == `SIR_ADDR_SYSMODE);

  // A change is only believed once the mode has been sampled after reset,
  // otherwise waking up in sleep mode would look like a transition.
  assign sleepChange = sleepPrimed && (sleepMode != sleepModeLast);

  // Both registers take a write in the cycle of the strobe.
  // Writes to other addresses belong to other blocks and are ignored here.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interruptEnable <= `SIR_ENABLE_RESET;
      interruptRouting <= `SIR_ROUTING_RESET;
    end
    else
    begin
      if (writeEnable)
      begin
        interruptEnable <= regWriteData;
      end
      if (writeRouting)
      begin
        interruptRouting <= regWriteData;
      end
    end
  end

  // Read data is registered and follows the read strobe by one cycle.
  // Addresses outside this block read as zero from here; the bus merges them.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regReadData <= `SIR_READ_NONE;
    end
    else if (regRead)
    begin
      case (regAddr)
        `SIR_ADDR_ENABLE:
        begin
          regReadData <= interruptEnable;
        end
        `SIR_ADDR_ROUTING:
        begin
          regReadData <= interruptRouting;
        end
        default:
        begin
          regReadData <= `SIR_READ_NONE;
        end
      endcase
    end
  end

  // Track the system mode to see each move between active and sleep.
  // The sample mark is set on the first edge after reset release.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleepModeLast <= 1'b0;
      sleepPrimed <= 1'b0;
    end
    else
    begin
      sleepModeLast <= sleepMode;
      sleepPrimed <= 1'b1;
    end
  end

  // The auto-sleep/wake flag is sticky until the host reads the mode register.
  // A transition in the very cycle of that read wins, so no event is lost.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleepEventFlag <= 1'b0;
    end
    else if (sleepChange)
    begin
      sleepEventFlag <= 1'b1;
    end
    else if (readSysMode)
    begin
      sleepEventFlag <= 1'b0;
    end
  end

  // The flag is raised whatever its enable bit says, so it is gated here
  // like every other source rather than at the point where it is set.
  assign rawFlags = {sleepEventFlag, sourceFlags};

  // Per-source gating and steering, one slice per bit.
  genvar i;
  generate
    for (i = 0; i < `SIR_SOURCES; i = i + 1)
    begin : gSource
      // A cleared enable bit keeps the flag away from both pins.
      assign next_enabledFlags[i] = rawFlags[i] & interruptEnable[i];
      // Routing bit one selects the first pin.
      assign toFirst[i] = next_enabledFlags[i] &
        (interruptRouting[i] == `SIR_ROUTE_FIRST);
      // Routing bit zero selects the second pin.
      assign toSecond[i] = next_enabledFlags[i] &
        (interruptRouting[i] == `SIR_ROUTE_SECOND);
    end
  endgenerate

  // Each pin is the OR of its steered sources and the magnetic requests.
  // The pin follows the flags as levels, so it holds while any one is set
  // and falls once each has been cleared at its own source or by its enable bit.
  assign firstActive = (|toFirst) | magToFirst;
  assign secondActive = (|toSecond) | magToSecond;

  // The pin alone cannot name its source, so the gated flags are offered
  // to the source status register that the host reads after an interrupt.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enabledFlags <= 8'h00;
    end
    else
    begin
      enabledFlags <= next_enabledFlags;
    end
  end

  // Output stage of the first interrupt pin.
  sir_pin_driver uFirstPin
  (
    .clk(clk),
    .reset_n(reset_n),
    .pinActive(firstActive),
    .polarityHigh(polarityHigh),
    .pinDriveKind(pinDriveKind),
    .pinOut(eventPinFirst),
    .pinOutEnable(eventPinFirstEnable)
  );

  // Output stage of the second interrupt pin.
  sir_pin_driver uSecondPin
  (
    .clk(clk),
    .reset_n(reset_n),
    .pinActive(secondActive),
    .polarityHigh(polarityHigh),
    .pinDriveKind(pinDriveKind),
    .pinOut(eventPinSecond),
    .pinOutEnable(eventPinSecondEnable)
  );

endmodule // sir_router

`default_nettype wire

// ---- hdl/sir_defs.vh ----
// Register offsets, field positions and reset values of the interrupt router.
`ifndef SIR_DEFS_VH
`define SIR_DEFS_VH

// Register offsets on the device register port.
`define SIR_ADDR_ENABLE 8'h2d
`define SIR_ADDR_ROUTING 8'h2e
`define SIR_ADDR_SYSMODE 8'h0b

// Reset values of the two registers.
`define SIR_ENABLE_RESET 8'h00
`define SIR_ROUTING_RESET 8'h00

// Bit positions shared by the enable and routing registers.
`define SIR_BIT_ASLP 7
`define SIR_BIT_FIFO 6
`define SIR_BIT_TRANS 5
`define SIR_BIT_ORIENT 4
`define SIR_BIT_PULSE 3
`define SIR_BIT_FFMT 2
`define SIR_BIT_AVECM 1
`define SIR_BIT_DRDY 0

// Number of acceleration-side sources.
`define SIR_SOURCES 8

// Routing bit values and pin control values.
`define SIR_ROUTE_SECOND 1'b0
`define SIR_ROUTE_FIRST 1'b1
`define SIR_POL_LOW 1'b0
`define SIR_DRIVE_PUSHPULL 1'b0

// Value read back from an address this block does not own.
`define SIR_READ_NONE 8'h00

`endif

// ---- hdl/sir_pin_driver.v ----
// Output stage of one interrupt pin: polarity and drive kind.
`timescale 1ns/100ps
`default_nettype none
`include "sir_defs.vh"

module sir_pin_driver
(
  input wire clk,
  input wire reset_n,
  input wire pinActive,
  input wire polarityHigh,
  input wire pinDriveKind,
  output reg pinOut,
  output reg pinOutEnable
);

  // Electrical level the pin should show for the current request.
  wire pinLevel;

  // Active low is the default, so an idle pin sits high.
  assign pinLevel = (polarityHigh == `SIR_POL_LOW) ? ~pinActive : pinActive;

  // The pin is registered so that glitches of the OR tree never reach the board.
  // Outside reset, open drain only pulls low; a high level is left to the external pull-up.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinOut <= 1'b1;
      pinOutEnable <= 1'b1;
    end
    else
    begin
      pinOut <= pinLevel;
      pinOutEnable <= (pinDriveKind == `SIR_DRIVE_PUSHPULL) | ~pinLevel;
    end
  end

endmodule // sir_pin_driver

`default_nettype wire

// ---- dv/sir_checker.sv ----
// Port checker for the interrupt router.
`timescale 1ns/100ps
`default_nettype none
module sir_checker
(
  input wire clk,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWriteData,
  input wire regRead,
  input wire [7:0] regReadData,
  input wire [6:0] sourceFlags,
  input wire sleepMode,
  input wire magToFirst,
  input wire magToSecond,
  input wire polarityHigh,
  input wire pinDriveKind,
  input wire sleepEventFlag,
  input wire [7:0] enabledFlags,
  input wire eventPinFirst,
  input wire eventPinFirstEnable,
  input wire eventPinSecond,
  input wire eventPinSecondEnable
);
  reg [7:0] en;
  reg [7:0] rt;
  reg armed;
  wire [7:0] raw = {sleepEventFlag, sourceFlags} & en;
  wire f = |(raw & rt) | magToFirst;
  wire s = |(raw & ~rt) | magToSecond;
  // Shadows follow host writes; armed skips the edge that only primes the mode sample.
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      en <= 8'h00;
      rt <= 8'h00;
      armed <= 1'b0;
    end
    else
    begin
      armed <= 1'b1;
      if (regWrite && regAddr == 8'h2d)
        en <= regWriteData;
      if (regWrite && regAddr == 8'h2e)
        rt <= regWriteData;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence sTrans;
    armed && $changed(sleepMode);
  endsequence
  AST_GATE: assert property (1 |=> enabledFlags == $past(raw))
    else $error("gated flags wrong");
  AST_RD_EN: assert property (regRead && regAddr == 8'h2d |=> regReadData == $past(en))
    else $error("enable readback wrong");
  AST_RD_RT: assert property (regRead && regAddr == 8'h2e |=> regReadData == $past(rt))
    else $error("routing readback wrong");
  AST_PIN1: assert property
    (1 |=> eventPinFirst == ($past(f) ~^ $past(polarityHigh)))
    else $error("first pin wrong");
  AST_PIN2: assert property
    (1 |=> eventPinSecond == ($past(s) ~^ $past(polarityHigh)))
    else $error("second pin wrong");
  AST_DRV1: assert property
    (1 |=> eventPinFirstEnable == (!$past(pinDriveKind) || !eventPinFirst))
    else $error("drive enable wrong");
  AST_DRV2: assert property
    (1 |=> eventPinSecondEnable == (!$past(pinDriveKind) || !eventPinSecond))
    else $error("second drive enable wrong");
  AST_SET: assert property (sTrans |=> sleepEventFlag)
    else $error("sleep flag not set");
  AST_HOLD: assert property
    (sleepEventFlag && !(regRead && regAddr == 8'h0b) |=> sleepEventFlag)
    else $error("sleep flag lost");
endmodule // sir_checker
bind sir_router sir_checker i_sir_checker (.clk, .reset_n, .regAddr, .regWrite, .regWriteData,
  .regRead, .regReadData, .sourceFlags, .sleepMode, .magToFirst, .magToSecond, .polarityHigh,
  .pinDriveKind, .sleepEventFlag, .enabledFlags, .eventPinFirst, .eventPinFirstEnable,
  .eventPinSecond, .eventPinSecondEnable);
`default_nettype wire

// ---- dv/sir_host_model.sv ----
// Host model that watches the two interrupt lines.
`timescale 1ns/100ps
`default_nettype none
module sir_host_model
(
  input wire pinF,
  input wire enF,
  input wire pinS,
  input wire enS,
  input wire polarityHigh,
  output wire irqF,
  output wire irqS
);
  // A released line sits at the pull-up level.
  wire lineF = enF ? pinF : 1'b1;
  wire lineS = enS ? pinS : 1'b1;
  // The line alone names no source, so the host then reads status.
  assign irqF = lineF == polarityHigh;
  assign irqS = lineS == polarityHigh;
endmodule // sir_host_model
`default_nettype wire

// ---- dv/tb_sir_router.sv ----
// Directed testbench for the interrupt router.
`timescale 1ns/100ps
`default_nettype none
module tb_sir_router;
  reg clk = 0, reset_n = 0, regWrite = 0, regRead = 0, sleepMode = 0;
  reg magToFirst = 0, magToSecond = 0, polarityHigh = 0, pinDriveKind = 0;
  reg [7:0] regAddr = 0, regWriteData = 0;
  reg [6:0] sourceFlags = 0;
  wire [7:0] regReadData, enabledFlags;
  wire sleepEventFlag, pF, eF, pS, eS, irqF, irqS;
  integer fail_count = 0, n_compared = 0, cyc = 0, i;
  always #25 clk = ~clk;
  sir_router i_sir_router (.clk, .reset_n, .regAddr, .regWrite, .regWriteData, .regRead,
    .regReadData, .sourceFlags, .sleepMode, .magToFirst, .magToSecond, .polarityHigh,
    .pinDriveKind, .sleepEventFlag, .enabledFlags, .eventPinFirst(pF),
    .eventPinFirstEnable(eF), .eventPinSecond(pS), .eventPinSecondEnable(eS));
  sir_host_model i_sir_host_model (.pinF(pF), .enF(eF), .pinS(pS), .enS(eS),
    .polarityHigh, .irqF, .irqS);
  task test_done;
    begin
      $display("compared %0d bad %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // A hung run is cut short and counted as a mismatch.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc > 2000)
    begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  // Inputs change a fixed 5 ns after the edge, away from sampling.
  task tk;
    begin
      @(posedge clk);
      #5;
    end
  endtask
  task ck8(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task ck2(input [1:0] exp);
    ck8({6'h00, irqF, irqS}, {6'h00, exp});
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      regAddr = a;
      regWriteData = d;
      regWrite = 1;
      tk;
      regWrite = 0;
      // One idle edge keeps back-to-back writes from touching the strobe twice at once.
      tk;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      regAddr = a;
      regRead = 1;
      tk;
      regRead = 0;
      ck8(regReadData, e);
      // Read data holds until the next read, so the idle edge costs nothing.
      tk;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #5 reset_n = 1;
    rd(8'h2d, 8'h00);
    rd(8'h2e, 8'h00);
    wr(8'h2d, 8'hff);
    wr(8'h2e, 8'ha5);
    wr(8'h55, 8'h33);
    rd(8'h2d, 8'hff);
    rd(8'h2e, 8'ha5);
    rd(8'h55, 8'h00);
    wr(8'h2d, 8'h00);
    $display("register test done");
    for (i = 0; i < 7; i = i + 1)
    begin
      sourceFlags = 7'h01 << i;
      wr(8'h2e, i[0] ? 8'h01 << i : 8'h00);
      tk;
      ck2(2'b00);
      wr(8'h2d, 8'h01 << i);
      tk;
      ck2(i[0] ? 2'b10 : 2'b01);
      ck8(enabledFlags, 8'h01 << i);
      wr(8'h2d, 8'h00);
    end
    $display("routing test done");
    wr(8'h2e, 8'h00);
    wr(8'h2d, 8'h7f);
    sourceFlags = 7'h05;
    tk;
    ck2(2'b01);
    sourceFlags = 7'h04;
    tk;
    ck2(2'b01);
    sourceFlags = 7'h00;
    tk;
    ck2(2'b00);
    magToFirst = 1;
    tk;
    ck2(2'b10);
    magToFirst = 0;
    magToSecond = 1;
    tk;
    ck2(2'b01);
    $display("or test done");
    polarityHigh = 1;
    tk;
    ck8({pF, pS}, 2'b01);
    pinDriveKind = 1;
    tk;
    ck8({eF, eS}, 2'b10);
    ck2(2'b01);
    polarityHigh = 0;
    tk;
    ck8({eF, eS}, 2'b01);
    ck2(2'b01);
    magToSecond = 0;
    pinDriveKind = 0;
    $display("pin test done");
    wr(8'h2e, 8'h80);
    wr(8'h2d, 8'h80);
    for (i = 0; i < 2; i = i + 1)
    begin
      sleepMode = !sleepMode;
      repeat (3) tk;
      ck2(2'b10);
      ck8({7'h00, sleepEventFlag}, 8'h01);
      rd(8'h0b, 8'h00);
      tk;
      ck2(2'b00);
      ck8({7'h00, sleepEventFlag}, 8'h00);
    end
    $display("sleep test done");
    test_done;
  end
endmodule // tb_sir_router
`default_nettype wire
